/* File: core/cac_pkg.sv */
// package for the charger auxiliary control block
// shared by the core and the bench; no tool assumptions
package cac_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  // apb register byte offsets
  localparam logic [7:0] OFF_ZONE_CFG = 8'h00;
  localparam logic [7:0] OFF_CHG_CFG = 8'h04;
  localparam logic [7:0] OFF_CFG_SEVEN = 8'h08;
  localparam logic [7:0] OFF_PIN_CFG = 8'h0C;
  localparam logic [7:0] OFF_DITHER_CFG = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_TARGETS = 8'h18;
  // timing
  localparam int unsigned T_LED_1HZ_HALF_MS = 500;
  localparam int unsigned T_LED_2HZ_HALF_MS = 250;
  localparam int unsigned T_ADAPTIVE_INPUT_LIMIT_MS = 1;
  localparam int unsigned T_SHIP_DEB_SHORT_MS = 100;
  localparam int unsigned T_SHIP_DEB_LONG_MS = 1000;
  localparam int unsigned T_UNPLUG_DEB_SHORT_MS = 1;
  localparam int unsigned T_UNPLUG_DEB_LONG_MS = 10;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_1HZ_HALF = T_LED_1HZ_HALF_MS * CYC_PER_MS;
  localparam int unsigned CYC_2HZ_HALF = T_LED_2HZ_HALF_MS * CYC_PER_MS;
  localparam int unsigned CYC_ADAPTIVE_INPUT_LIMIT = T_ADAPTIVE_INPUT_LIMIT_MS * CYC_PER_MS;
  localparam int unsigned CYC_SHIP_SHORT = T_SHIP_DEB_SHORT_MS * CYC_PER_MS;
  localparam int unsigned CYC_SHIP_LONG = T_SHIP_DEB_LONG_MS * CYC_PER_MS;
  localparam int unsigned CYC_UNPL_SHORT = T_UNPLUG_DEB_SHORT_MS * CYC_PER_MS;
  localparam int unsigned CYC_UNPL_LONG = T_UNPLUG_DEB_LONG_MS * CYC_PER_MS;
  // audio bootstrap refresh and dither repeat rates in hz
  localparam int unsigned F_AUDIO_REFRESH_HZ = 64000;
  localparam int unsigned F_TRI_HZ_X3 = 6400;
  localparam int unsigned F_PRN_HZ_X3 = 12800;
  localparam int unsigned F_TRI_AUDIO_HZ = 133;
  localparam int unsigned F_PRN_AUDIO_HZ = 267;
  localparam logic [16:0] DIV_AUDIO = 17'(CLK_HZ / F_AUDIO_REFRESH_HZ);
  localparam logic [16:0] DIV_TRI = 17'((3 * CLK_HZ) / F_TRI_HZ_X3);
  localparam logic [16:0] DIV_PRN = 17'((3 * CLK_HZ) / F_PRN_HZ_X3);
  localparam logic [16:0] DIV_TRI_AUDIO = 17'(CLK_HZ / F_TRI_AUDIO_HZ);
  localparam logic [16:0] DIV_PRN_AUDIO = 17'(CLK_HZ / F_PRN_AUDIO_HZ);
  localparam int unsigned CNT_W = 24;
  // field values
  localparam logic [3:0] MODE_BOOST = 4'h9;
  localparam logic [3:0] MODE_BOOST_OTG = 4'hA;
  localparam logic [5:0] UNPLUG_OFF = 6'h00;
  localparam logic [5:0] UNPLUG_5V = 6'h01;
  localparam logic [1:0] ENV_OFF = 2'h0;
  localparam logic [2:0] ZONE_CODE_COLD = 3'h0;
  localparam logic [2:0] ZONE_CODE_COOL = 3'h1;
  localparam logic [2:0] ZONE_CODE_NORMAL = 3'h2;
  localparam logic [2:0] ZONE_CODE_WARM = 3'h3;
  localparam logic [2:0] ZONE_CODE_HOT = 3'h4;
  localparam logic [3:0] DTLS_CHARGING = 4'h0;
  localparam logic [3:0] DTLS_TEMP_SUSPEND = 4'h1;
  localparam logic [3:0] DTLS_OFF = 4'h2;

  typedef enum logic [1:0] {LED_OFF, LED_FAST, LED_SLOW, LED_SOLID} cac_led_e;

  // charger status from the analog side
  typedef struct packed {
    logic chg_valid;
    logic buck_on;
    logic suspend;
    logic deep_suspend;
    logic battery_present;
    logic dcm;
    logic charging;
    logic top_off_done;
    logic fault_stop;
    logic above_unplug;
    logic adaptive_input_limit_low_current;
    logic headroom_low;
  } cac_ana_s;

  // targets handed to the regulation loops
  typedef struct packed {
    logic [7:0] cur;
    logic [7:0] volt;
    logic charge_en;
    logic timer_double;
    logic timer_reset;
  } cac_tgt_s;
endpackage

/* File: core/cac_top.sv */
// charger auxiliary control: zones, ship mode, ext pin, led, dither
// assumes apb master on clk, analog status synchronous except thermistor
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module cac_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] thermistor_input,
  input wire cac_pkg::cac_ana_s ana,
  input wire logic ship_exit_pin,
  output logic ext_switch_drive_pin_o,
  output logic ext_switch_drive_pin_oe_n,
  output logic led_on,
  output logic ship_mode_active,
  output logic charge_irq_pulse,
  output cac_pkg::cac_tgt_s tgt,
  output logic bootstrap_refresh,
  output logic [1:0] dither_envelope_o,
  output logic dither_pattern_o,
  output logic dither_active,
  output logic dither_tick,
  output logic [2:0] min_system_voltage_o
);
  // registers
  logic temp_zone_charge_enable_r, temp_zone_charge_enable_nxt;
  logic [7:0] fast_charge_current_r, fast_charge_current_nxt;
  logic [7:0] warm_zone_current_r, warm_zone_current_nxt;
  logic [7:0] termination_voltage_r, termination_voltage_nxt;
  logic [7:0] cool_zone_voltage_r, cool_zone_voltage_nxt;
  logic [7:0] warm_voltage_backoff_r, warm_voltage_backoff_nxt;
  logic [3:0] mode_r, mode_nxt;
  logic ship_req_wr, ship_exit_debounce_sel_r, ship_exit_debounce_sel_nxt;
  logic ext_switch_output_enable_r, ext_switch_output_enable_nxt;
  logic [5:0] unplug_threshold_r, unplug_threshold_nxt;
  logic unplug_debounce_sel_r, unplug_debounce_sel_nxt;
  logic adaptive_input_limit_en_r, adaptive_input_limit_en_nxt;
  logic led_mode_r, led_mode_nxt;
  logic audio_mode_r, audio_mode_nxt;
  logic [1:0] dither_envelope_r, dither_envelope_nxt;
  logic dither_pattern_r, dither_pattern_nxt;
  logic [2:0] min_system_voltage_r, min_system_voltage_nxt;
  logic wr_en, rd_hit;
  logic [31:0] rd_data;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb begin
    temp_zone_charge_enable_nxt = temp_zone_charge_enable_r;
    fast_charge_current_nxt = fast_charge_current_r;
    warm_zone_current_nxt = warm_zone_current_r;
    termination_voltage_nxt = termination_voltage_r;
    cool_zone_voltage_nxt = cool_zone_voltage_r;
    warm_voltage_backoff_nxt = warm_voltage_backoff_r;
    mode_nxt = mode_r;
    ship_exit_debounce_sel_nxt = ship_exit_debounce_sel_r;
    ext_switch_output_enable_nxt = ext_switch_output_enable_r;
    unplug_threshold_nxt = unplug_threshold_r;
    unplug_debounce_sel_nxt = unplug_debounce_sel_r;
    adaptive_input_limit_en_nxt = adaptive_input_limit_en_r;
    led_mode_nxt = led_mode_r;
    audio_mode_nxt = audio_mode_r;
    dither_envelope_nxt = dither_envelope_r;
    dither_pattern_nxt = dither_pattern_r;
    min_system_voltage_nxt = min_system_voltage_r;
    ship_req_wr = 1'b0;
    if (wr_en) begin
      unique case (paddr)
        cac_pkg::OFF_ZONE_CFG: begin
          temp_zone_charge_enable_nxt = pwdata[0];
          warm_zone_current_nxt = pwdata[15:8];
          cool_zone_voltage_nxt = pwdata[23:16];
          warm_voltage_backoff_nxt = pwdata[31:24];
        end
        cac_pkg::OFF_CHG_CFG: begin
          fast_charge_current_nxt = pwdata[7:0];
          termination_voltage_nxt = pwdata[15:8];
          mode_nxt = pwdata[19:16];
          min_system_voltage_nxt = pwdata[22:20];
        end
        cac_pkg::OFF_CFG_SEVEN: begin
          ship_req_wr = pwdata[0];
          ship_exit_debounce_sel_nxt = pwdata[1];
        end
        cac_pkg::OFF_PIN_CFG: begin
          ext_switch_output_enable_nxt = pwdata[0];
          unplug_threshold_nxt = pwdata[13:8];
          unplug_debounce_sel_nxt = pwdata[16];
          adaptive_input_limit_en_nxt = pwdata[17];
          led_mode_nxt = pwdata[24];
        end
        cac_pkg::OFF_DITHER_CFG: begin
          dither_envelope_nxt = pwdata[1:0];
          dither_pattern_nxt = pwdata[4];
          audio_mode_nxt = pwdata[8];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      temp_zone_charge_enable_r <= 1'b1;
      fast_charge_current_r <= 8'h00;
      warm_zone_current_r <= 8'h00;
      termination_voltage_r <= 8'h00;
      cool_zone_voltage_r <= 8'h00;
      warm_voltage_backoff_r <= 8'h00;
      mode_r <= 4'h0;
      ship_exit_debounce_sel_r <= 1'b0;
      ext_switch_output_enable_r <= 1'b0;
      unplug_threshold_r <= cac_pkg::UNPLUG_OFF;
      unplug_debounce_sel_r <= 1'b0;
      adaptive_input_limit_en_r <= 1'b0;
      led_mode_r <= 1'b0;
      audio_mode_r <= 1'b0;
      dither_envelope_r <= cac_pkg::ENV_OFF;
      dither_pattern_r <= 1'b0;
      min_system_voltage_r <= 3'h0;
    end else begin
      temp_zone_charge_enable_r <= temp_zone_charge_enable_nxt;
      fast_charge_current_r <= fast_charge_current_nxt;
      warm_zone_current_r <= warm_zone_current_nxt;
      termination_voltage_r <= termination_voltage_nxt;
      cool_zone_voltage_r <= cool_zone_voltage_nxt;
      warm_voltage_backoff_r <= warm_voltage_backoff_nxt;
      mode_r <= mode_nxt;
      ship_exit_debounce_sel_r <= ship_exit_debounce_sel_nxt;
      ext_switch_output_enable_r <= ext_switch_output_enable_nxt;
      unplug_threshold_r <= unplug_threshold_nxt;
      unplug_debounce_sel_r <= unplug_debounce_sel_nxt;
      adaptive_input_limit_en_r <= adaptive_input_limit_en_nxt;
      led_mode_r <= led_mode_nxt;
      audio_mode_r <= audio_mode_nxt;
      dither_envelope_r <= dither_envelope_nxt;
      dither_pattern_r <= dither_pattern_nxt;
      min_system_voltage_r <= min_system_voltage_nxt;
    end
  end

  // thermistor comparators: [0] above cold, [1] above cool, [2] above warm, [3] above hot
  logic [3:0] thm_meta_r, thm_sync_r;
  logic [2:0] zone_code;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      thm_meta_r <= 4'h0;
      thm_sync_r <= 4'h0;
    end else begin
      thm_meta_r <= thermistor_input;
      thm_sync_r <= thm_meta_r;
    end
  end

  always_comb begin
    if (!thm_sync_r[0]) zone_code = cac_pkg::ZONE_CODE_COLD;
    else if (thm_sync_r[3]) zone_code = cac_pkg::ZONE_CODE_HOT;
    else if (thm_sync_r[2]) zone_code = cac_pkg::ZONE_CODE_WARM;
    else if (!thm_sync_r[1]) zone_code = cac_pkg::ZONE_CODE_COOL;
    else zone_code = cac_pkg::ZONE_CODE_NORMAL;
  end

  // zone charging targets
  logic zone_en, in_cool, in_warm, temp_susp;
  logic temp_susp_r, temp_susp_nxt;
  logic [3:0] charge_detail_status_r, charge_detail_status_nxt;
  assign zone_en = temp_zone_charge_enable_r;
  assign in_cool = zone_en && (zone_code == cac_pkg::ZONE_CODE_COOL);
  assign in_warm = zone_en && (zone_code == cac_pkg::ZONE_CODE_WARM);
  assign temp_susp = zone_en && ((zone_code == cac_pkg::ZONE_CODE_COLD) ||
                                 (zone_code == cac_pkg::ZONE_CODE_HOT));

  always_comb begin
    tgt.cur = fast_charge_current_r;
    tgt.volt = termination_voltage_r;
    if (in_warm) begin
      tgt.cur = warm_zone_current_r;
      // saturate so a large backoff cannot wrap the target
      tgt.volt = (termination_voltage_r > warm_voltage_backoff_r) ?
                 8'(termination_voltage_r - warm_voltage_backoff_r) : 8'h00;
    end else if (in_cool) begin
      tgt.cur = {1'b0, fast_charge_current_r[7:1]};
      tgt.volt = cool_zone_voltage_r;
    end
    tgt.charge_en = !temp_susp;
    tgt.timer_double = in_cool;
    tgt.timer_reset = temp_susp_r != temp_susp;
  end

  always_comb begin
    temp_susp_nxt = temp_susp;
    if (temp_susp) charge_detail_status_nxt = cac_pkg::DTLS_TEMP_SUSPEND;
    else if (ana.charging) charge_detail_status_nxt = cac_pkg::DTLS_CHARGING;
    else charge_detail_status_nxt = cac_pkg::DTLS_OFF;
  end
  assign charge_irq_pulse = temp_susp && !temp_susp_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      temp_susp_r <= 1'b0;
      charge_detail_status_r <= cac_pkg::DTLS_OFF;
    end else begin
      temp_susp_r <= temp_susp_nxt;
      charge_detail_status_r <= charge_detail_status_nxt;
    end
  end

  // ship mode and exit debounce
  logic ship_r, ship_nxt;
  logic [cac_pkg::CNT_W-1:0] ship_cnt_r, ship_cnt_nxt, ship_lim;
  assign ship_lim = ship_exit_debounce_sel_r ? cac_pkg::CNT_W'(cac_pkg::CYC_SHIP_LONG) :
                    cac_pkg::CNT_W'(cac_pkg::CYC_SHIP_SHORT);
  always_comb begin
    ship_nxt = ship_r;
    ship_cnt_nxt = '0;
    if (ship_r) begin
      if (!ship_exit_pin) ship_cnt_nxt = ship_cnt_r + 1'b1;
      if (!ana.battery_present || ana.chg_valid || (ship_cnt_r >= ship_lim)) ship_nxt = 1'b0;
    end else if (ship_req_wr && !ana.chg_valid) begin
      ship_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ship_r <= 1'b0;
      ship_cnt_r <= '0;
    end else begin
      ship_r <= ship_nxt;
      ship_cnt_r <= ship_cnt_nxt;
    end
  end
  assign ship_mode_active = ship_r;

  // power good comparator and debounce
  logic pg_raw, pg_r, pg_nxt, pg_pin_low;
  logic [cac_pkg::CNT_W-1:0] pg_cnt_r, pg_cnt_nxt, pg_lim;
  logic otg_mode;
  assign otg_mode = (mode_r == cac_pkg::MODE_BOOST) || (mode_r == cac_pkg::MODE_BOOST_OTG);
  always_comb begin
    if (unplug_threshold_r == cac_pkg::UNPLUG_5V) begin
      if (adaptive_input_limit_en_r) pg_raw = ana.chg_valid && !ana.adaptive_input_limit_low_current;
      else pg_raw = ana.chg_valid && !ana.headroom_low;
      pg_lim = adaptive_input_limit_en_r ? cac_pkg::CNT_W'(cac_pkg::CYC_ADAPTIVE_INPUT_LIMIT) : '0;
    end else begin
      pg_raw = ana.above_unplug;
      pg_lim = unplug_debounce_sel_r ? cac_pkg::CNT_W'(cac_pkg::CYC_UNPL_LONG) :
               cac_pkg::CNT_W'(cac_pkg::CYC_UNPL_SHORT);
    end
    pg_nxt = pg_r;
    pg_cnt_nxt = '0;
    // only the loss of input is debounced; recovery is immediate
    if (pg_raw) pg_nxt = 1'b1;
    else if (pg_cnt_r >= pg_lim) pg_nxt = 1'b0;
    else pg_cnt_nxt = pg_cnt_r + 1'b1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pg_r <= 1'b0;
      pg_cnt_r <= '0;
    end else begin
      pg_r <= pg_nxt;
      pg_cnt_r <= pg_cnt_nxt;
    end
  end
  assign pg_pin_low = pg_r && !ship_r && !ana.deep_suspend && !otg_mode;

  // external switch / power good open drain pin
  logic ext_low;
  always_comb begin
    if (unplug_threshold_r != cac_pkg::UNPLUG_OFF) ext_low = pg_pin_low;
    else ext_low = ext_switch_output_enable_r &&
                   !((ana.chg_valid && ana.buck_on) || otg_mode);
  end
  assign ext_switch_drive_pin_o = 1'b0;
  assign ext_switch_drive_pin_oe_n = !ext_low;

  // status led
  cac_pkg::cac_led_e led_cls, led_cls_r;
  logic [cac_pkg::CNT_W-1:0] blink_cnt_r, blink_cnt_nxt, blink_lim;
  logic blink_ph_r, blink_ph_nxt;
  always_comb begin
    if (!ana.chg_valid || ana.suspend) led_cls = cac_pkg::LED_OFF;
    else if (ana.fault_stop || temp_susp) led_cls = led_mode_r ? cac_pkg::LED_OFF : cac_pkg::LED_FAST;
    else if (ana.top_off_done) led_cls = cac_pkg::LED_SOLID;
    else if (ana.charging) led_cls = cac_pkg::LED_SLOW;
    else led_cls = cac_pkg::LED_OFF;
    blink_lim = (led_cls == cac_pkg::LED_FAST) ? cac_pkg::CNT_W'(cac_pkg::CYC_2HZ_HALF - 1) :
                cac_pkg::CNT_W'(cac_pkg::CYC_1HZ_HALF - 1);
    blink_cnt_nxt = blink_cnt_r + 1'b1;
    blink_ph_nxt = blink_ph_r;
    if (led_cls != led_cls_r) begin
      blink_cnt_nxt = '0;
      blink_ph_nxt = 1'b1;
    end else if (blink_cnt_r >= blink_lim) begin
      blink_cnt_nxt = '0;
      blink_ph_nxt = !blink_ph_r;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      led_cls_r <= cac_pkg::LED_OFF;
      blink_cnt_r <= '0;
      blink_ph_r <= 1'b1;
      led_on <= 1'b0;
    end else begin
      led_cls_r <= led_cls;
      blink_cnt_r <= blink_cnt_nxt;
      blink_ph_r <= blink_ph_nxt;
      unique case (led_cls)
        cac_pkg::LED_OFF: led_on <= 1'b0;
        cac_pkg::LED_SOLID: led_on <= 1'b1;
        cac_pkg::LED_FAST, cac_pkg::LED_SLOW: led_on <= blink_ph_nxt;
      endcase
    end
  end

  // audio refresh and dither repeat tick
  logic [16:0] aud_cnt_r, aud_cnt_nxt, dit_cnt_r, dit_cnt_nxt, dit_div;
  logic dither_on;
  assign dither_on = (dither_envelope_r != cac_pkg::ENV_OFF) && !ana.dcm;
  always_comb begin
    if (audio_mode_r) dit_div = dither_pattern_r ? cac_pkg::DIV_PRN_AUDIO : cac_pkg::DIV_TRI_AUDIO;
    else dit_div = dither_pattern_r ? cac_pkg::DIV_PRN : cac_pkg::DIV_TRI;
    aud_cnt_nxt = '0;
    if (audio_mode_r && (aud_cnt_r < cac_pkg::DIV_AUDIO - 17'h00001)) aud_cnt_nxt = aud_cnt_r + 17'h00001;
    dit_cnt_nxt = '0;
    if (dither_on && (dit_cnt_r < dit_div - 17'h00001)) dit_cnt_nxt = dit_cnt_r + 17'h00001;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aud_cnt_r <= '0;
      dit_cnt_r <= '0;
      bootstrap_refresh <= 1'b0;
      dither_tick <= 1'b0;
    end else begin
      aud_cnt_r <= aud_cnt_nxt;
      dit_cnt_r <= dit_cnt_nxt;
      bootstrap_refresh <= audio_mode_r && (aud_cnt_r == cac_pkg::DIV_AUDIO - 17'h00001);
      dither_tick <= dither_on && (dit_cnt_r == dit_div - 17'h00001);
    end
  end
  assign dither_active = dither_on;
  assign dither_envelope_o = dither_on ? dither_envelope_r : cac_pkg::ENV_OFF;
  assign dither_pattern_o = dither_pattern_r;
  assign min_system_voltage_o = min_system_voltage_r;

  // apb read
  always_comb begin
    rd_hit = 1'b1;
    rd_data = '0;
    unique case (paddr)
      cac_pkg::OFF_ZONE_CFG: rd_data = {warm_voltage_backoff_r, cool_zone_voltage_r, warm_zone_current_r,
                                        7'h00, temp_zone_charge_enable_r};
      cac_pkg::OFF_CHG_CFG: rd_data = {9'h000, min_system_voltage_r, mode_r, termination_voltage_r,
                                       fast_charge_current_r};
      cac_pkg::OFF_CFG_SEVEN: rd_data = {30'h0, ship_exit_debounce_sel_r, ship_r};
      cac_pkg::OFF_PIN_CFG: rd_data = {7'h00, led_mode_r, 6'h00, adaptive_input_limit_en_r, unplug_debounce_sel_r,
                                       2'h0, unplug_threshold_r, 7'h00, ext_switch_output_enable_r};
      cac_pkg::OFF_DITHER_CFG: rd_data = {23'h0, audio_mode_r, 3'h0, dither_pattern_r, 2'h0, dither_envelope_r};
      cac_pkg::OFF_STATUS: rd_data = {20'h0, dither_on, led_on, pg_r, ship_r, 1'b0, zone_code,
                                      charge_detail_status_r};
      cac_pkg::OFF_TARGETS: rd_data = {13'h0, tgt.timer_double, tgt.charge_en, 1'b0, tgt.volt, tgt.cur};
      default: rd_hit = 1'b0;
    endcase
  end
  assign prdata = rd_data;
  assign pslverr = psel && penable && !rd_hit;
endmodule
`default_nettype wire

/* File: tb/cac_therm_model.sv */
// thermistor and ship button model for the charger bench
// assumes the bench picks a zone code 0 to 4
`timescale 1ns/10ps
`default_nettype none
module cac_therm_model (
  input wire logic [2:0] zone,
  output logic [3:0] thermistor_input,
  output logic ship_exit_pin
);
  // comparators trip in order as the pack warms
  assign thermistor_input = 4'(5'h0F >> (3'h4 - zone));
  // button pulled up, never pressed: debounce longer than the run
  assign ship_exit_pin = 1'b1;
endmodule
`default_nettype wire

/* File: tb/cac_props.sv */
// port checker for cac_top
// assumes one clock, synchronous reset
`timescale 1ns/10ps
`default_nettype none
module cac_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire cac_pkg::cac_ana_s ana,
  input wire logic ext_switch_drive_pin_o,
  input wire logic ship_mode_active,
  input wire logic charge_irq_pulse,
  input wire cac_pkg::cac_tgt_s tgt,
  input wire logic bootstrap_refresh,
  input wire logic [1:0] dither_envelope_o,
  input wire logic dither_active,
  input wire logic dither_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_boot_quiet;
    !bootstrap_refresh [*8];
  endsequence
  sequence s_ship_gone;
    ##[1:3] !ship_mode_active;
  endsequence
  property p_pin_low; ext_switch_drive_pin_o == 1'b0; endproperty
  property p_irq_stop; charge_irq_pulse |-> tgt.timer_reset && !tgt.charge_en; endproperty
  property p_irq_once; charge_irq_pulse |=> !charge_irq_pulse; endproperty
  property p_treset_once; tgt.timer_reset |=> !tgt.timer_reset; endproperty
  property p_dither_ccm; dither_active |-> !ana.dcm && dither_envelope_o != cac_pkg::ENV_OFF; endproperty
  property p_tick_once; dither_tick |=> !dither_tick; endproperty
  property p_boot_space; bootstrap_refresh |=> s_boot_quiet; endproperty
  property p_ship_refuse; $rose(ship_mode_active) |-> !$past(ana.chg_valid); endproperty
  property p_ship_exit; ship_mode_active && (ana.chg_valid || !ana.battery_present) |-> s_ship_gone; endproperty
  a_pin_low: assert property (p_pin_low) else $error("ext pin data not low");
  a_irq_stop: assert property (p_irq_stop) else $error("irq without suspend");
  a_irq_once: assert property (p_irq_once) else $error("irq longer than a cycle");
  a_treset_once: assert property (p_treset_once) else $error("timer reset too long");
  a_dither_ccm: assert property (p_dither_ccm) else $error("dither outside ccm");
  a_tick_once: assert property (p_tick_once) else $error("tick too long");
  a_boot_space: assert property (p_boot_space) else $error("refresh too dense");
  a_ship_refuse: assert property (p_ship_refuse) else $error("ship entered on input");
  a_ship_exit: assert property (p_ship_exit) else $error("ship not left");
endmodule
bind cac_top cac_props cac_props_inst (.clk(clk), .sys_rst(sys_rst), .ana(ana),
  .ext_switch_drive_pin_o(ext_switch_drive_pin_o), .ship_mode_active(ship_mode_active),
  .charge_irq_pulse(charge_irq_pulse), .tgt(tgt), .bootstrap_refresh(bootstrap_refresh),
  .dither_envelope_o(dither_envelope_o), .dither_active(dither_active), .dither_tick(dither_tick));
`default_nettype wire

/* File: tb/charger_aux_control_logic_test.sv */
// self-checking bench for cac_top
// assumes apb answers at once and the model sets thermistor levels
`timescale 1ns/10ps
`default_nettype none
module charger_aux_control_logic_test;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, er, ship_exit_pin, pin_o, oe_n;
  logic led_on, ship, irq, boot, dact, dtick, pat_o;
  logic [7:0] paddr, cc, cv, coolv, warmc, bo;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] thermistor_input;
  logic [2:0] zone, zv, msv, msv_o;
  logic [1:0] env_o;
  cac_pkg::cac_ana_s ana, av;
  cac_pkg::cac_tgt_s tgt;
  int errors, checked, n_irq, n_tr, z, k, n;
  cac_top cac_top_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .thermistor_input(thermistor_input), .ana(ana), .ship_exit_pin(ship_exit_pin),
    .ext_switch_drive_pin_o(pin_o), .ext_switch_drive_pin_oe_n(oe_n), .led_on(led_on),
    .ship_mode_active(ship), .charge_irq_pulse(irq), .tgt(tgt), .bootstrap_refresh(boot),
    .dither_envelope_o(env_o), .dither_pattern_o(pat_o), .dither_active(dact), .dither_tick(dtick),
    .min_system_voltage_o(msv_o));
  cac_therm_model cac_therm_model_inst (.zone(zone), .thermistor_input(thermistor_input),
    .ship_exit_pin(ship_exit_pin));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // negedge sampling: pulses are combinational off registered state
  always @(negedge clk) begin
    if (irq === 1'b1) n_irq++;
    if (tgt.timer_reset === 1'b1) n_tr++;
  end
  task give_verdict;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (i >= 20) cmp(pready, 1);
    if (i >= 20) give_verdict;
  endtask
  task put;
    @(posedge clk);
    ana <= av;
    zone <= zv;
  endtask
  task settle(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask
  task wait_oe(input logic v, input int b);
    int i;
    for (i = 0; i < b && oe_n !== v; i++) @(negedge clk);
    cmp(oe_n, v);
    if (oe_n !== v) give_verdict;
  endtask
  task meas(input logic s, input int d);
    int i;
    for (i = 0; i < 9000 && (s ? boot : dtick) !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    for (n = 1; n < 9000 && (s ? boot : dtick) !== 1'b1; n++) @(negedge clk);
    cmp(n >= d - 1 && n <= d + 1, 1);
  endtask
  function automatic logic [16:0] exp_t(input logic en, input int zz);
    logic [7:0] c, v;
    c = en && zz == 1 ? cc >> 1 : en && zz == 3 ? warmc : cc;
    v = en && zz == 1 ? coolv : en && zz == 3 ? cv - bo : cv;
    return {c, v, en && zz == 1};
  endfunction
  initial begin
    {psel, penable, pwrite, paddr, pwdata, av, ana} = '0;
    {errors, checked, n_irq, n_tr} = '0;
    zv = cac_pkg::ZONE_CODE_NORMAL;
    zone = zv;
    sys_rst = 1;
    repeat (6) @(posedge clk);
    sys_rst <= 0;
    k = $urandom(32'h4D9C59F5);
    for (k = 0; k < 5; k++) begin
      apb(0, 8'(4 * k), 0);
      cmp(rd, k == 0);
    end
    apb(0, 8'h40, 0);
    cmp({31'h0, er}, 32'h1);
    cmp(rd, 32'h0);
    {cc, cv, bo, coolv, warmc} = {8'($urandom_range(255, 2)), 8'($urandom_range(255, 128)),
      8'($urandom_range(63, 1)), 16'($urandom)};
    msv = 3'($urandom);
    apb(1, cac_pkg::OFF_CHG_CFG, {9'h0, msv, 4'h0, cv, cc});
    apb(1, cac_pkg::OFF_ZONE_CFG, {bo, coolv, warmc, 8'h01});
    cmp(msv_o, msv);
    {av.chg_valid, av.battery_present, av.charging} = 3'h7;
    put;
    settle(5);
    {n_irq, n_tr} = '0;
    for (k = 0; k < 2; k++) begin
      if (k == 1) cmp(n_irq, 2);
      if (k == 1) cmp(n_tr, 3);
      if (k == 1) apb(1, cac_pkg::OFF_ZONE_CFG, {bo, coolv, warmc, 8'h00});
      for (z = 0; z < 5; z++) begin
        zv = 3'(z);
        put;
        settle(5);
        cmp({tgt.cur, tgt.volt, tgt.timer_double}, exp_t(k == 0, z));
        if (k == 0 && z % 4 == 0) cmp(tgt.charge_en, 0);
        apb(0, cac_pkg::OFF_STATUS, 0);
        cmp(rd[3:0] == cac_pkg::DTLS_TEMP_SUSPEND, k == 0 && z % 4 == 0);
        if (k == 0) cmp(rd[6:4], z);
      end
    end
    apb(1, cac_pkg::OFF_CFG_SEVEN, 1);
    settle(3);
    cmp(ship, 0);
    for (k = 0; k < 2; k++) begin
      av.chg_valid = 0;
      put;
      apb(1, cac_pkg::OFF_CFG_SEVEN, 1);
      settle(3);
      cmp(ship, 1);
      if (k == 0) av.chg_valid = 1;
      else av.battery_present = 0;
      put;
      settle(4);
      cmp(ship, 0);
      av.battery_present = 1;
    end
    // table of battery mode versus adapter, buck and boost modes
    apb(1, cac_pkg::OFF_PIN_CFG, 1);
    for (k = 0; k < 6; k++) begin
      av.chg_valid = k == 1 || k == 2;
      av.buck_on = k == 1;
      put;
      apb(1, cac_pkg::OFF_CHG_CFG, {12'h0, k == 3 ? 4'h9 : k == 4 ? 4'hA : 4'h0, cv, cc});
      if (k == 5) apb(1, cac_pkg::OFF_PIN_CFG, 0);
      settle(2);
      cmp(oe_n, 6'b111010 >> k & 1);
    end
    apb(1, cac_pkg::OFF_PIN_CFG, 32'h0201);
    {av.chg_valid, av.above_unplug} = 2'h3;
    put;
    settle(3);
    cmp(oe_n, 0);
    av.above_unplug = 0;
    put;
    settle(5000);
    cmp(oe_n, 0);
    wait_oe(1, 8000);
    av.above_unplug = 1;
    put;
    wait_oe(0, 10);
    av.deep_suspend = 1;
    put;
    wait_oe(1, 12000);
    av = '0;
    {av.chg_valid, av.battery_present, av.top_off_done} = 3'h7;
    put;
    apb(1, cac_pkg::OFF_PIN_CFG, 0);
    settle(3);
    cmp(led_on, 1);
    {av.top_off_done, av.fault_stop} = 2'h1;
    put;
    settle(3);
    cmp(led_on, 1);
    apb(1, cac_pkg::OFF_PIN_CFG, 32'h0100_0000);
    settle(3);
    cmp(led_on, 0);
    {av.chg_valid, av.buck_on, av.fault_stop} = 3'h6;
    put;
    for (k = 0; k < 4; k++) begin
      apb(1, cac_pkg::OFF_DITHER_CFG, k | (k == 3) << 4);
      settle(2);
      cmp({env_o, pat_o, dact}, {2'(k), k == 3, k != 0});
    end
    meas(0, (3 * cac_pkg::CLK_HZ) / cac_pkg::F_PRN_HZ_X3);
    apb(1, cac_pkg::OFF_DITHER_CFG, 1);
    meas(0, (3 * cac_pkg::CLK_HZ) / cac_pkg::F_TRI_HZ_X3);
    av.dcm = 1;
    put;
    settle(2);
    cmp(dact, 0);
    apb(1, cac_pkg::OFF_DITHER_CFG, 32'h100);
    meas(1, cac_pkg::CLK_HZ / cac_pkg::F_AUDIO_REFRESH_HZ);
    give_verdict;
  end
endmodule
`default_nettype wire
